// *** prof_buf_consts.svh ***
// Constants for the profiling buffer control block: fields, codes, resets.
// Assumes inclusion by prof_buf_pkg and prof_buf_ctrl only.
`ifndef PROF_BUF_CONSTS_SVH
`define PROF_BUF_CONSTS_SVH

`define REG_SEL_CAP 2'h0
`define REG_SEL_UPPER 2'h1
`define REG_SEL_CURSOR 2'h2
`define REG_SEL_SYND 2'h3

`define CAP_FLAG_BIT 5
`define CAP_PROHIB_BIT 4
`define UPPER_LIMIT_LSB 12
`define UPPER_FILL_LSB 1
`define UPPER_ENABLE_BIT 0
`define SYND_EC_LSB 26
`define SYND_LOST_BIT 19
`define SYND_EXTAB_BIT 18
`define SYND_SERVICE_BIT 17
`define SYND_OVERLAP_SEEN_FLAG_BIT 16

`define EC_STAGE1 6'h24
`define EC_STAGE2 6'h25
`define EC_OTHER 6'h00
`define BSC_NOT_FILLED 6'h00
`define BSC_FILLED 6'h01
`define FSC_SYNC_EXT 6'h10
`define FSC_ASYNC_EXT 6'h11
`define FSC_ALIGN 6'h21
`define FSC_TLB_CONFLICT 6'h30
`define FSC_UNSUPPORTED 6'h35

`define FILL_STOP 2'h0
`define OWN_00 2'h0
`define OWN_01 2'h1
`define OWN_10 2'h2
`define OWN_11 2'h3
`define ALIGN_MAX 4'hb
`define UPPER_RESET 64'h0000_0000_0000_0000

`endif

// *** prof_buf_ctrl.sv ***
// Profiling buffer control and status registers, with record writer.
// Assumes a system-register port from the core and a memory write port.
`default_nettype none
`include "prof_buf_consts.svh"

module prof_buf_ctrl
	import prof_buf_pkg::*;
#(
	parameter logic [3:0] ALIGN_CODE = 4'h3,
	parameter logic FLAG_UPDATE = 1'b1,
	parameter int GRANULE_LOG2 = 12,
	parameter logic SYNC_ABORT_REPORT = 1'b1,
	parameter int REC_W = 16,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// System register access
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [1:0] reg_sel,
	input wire logic [63:0] reg_wdata,
	input wire prof_buf_pkg::level_type cur_level,
	input wire logic [1:0] top_level_ownership_field,
	input wire logic [1:0] hypervisor_ownership_field,
	output logic [63:0] reg_rdata,
	output logic reg_ack,
	output logic trap_el2,
	output logic trap_el3,
	// Record source, length in bytes per record
	input wire logic rec_valid,
	output logic rec_ready,
	input wire logic [REC_W-1:0] rec_len,
	input wire logic collision_event,
	// Memory write port
	output logic mem_wr,
	output logic [63:0] mem_addr,
	output logic [REC_W-1:0] mem_len,
	input wire logic mem_done,
	input wire prof_buf_pkg::fault_type mem_fault,
	input wire logic [5:0] mem_fsc,
	input wire logic partial_write,
	// Management interrupt
	output logic buffer_management_interrupt
);
	// Refuse settings the logic cannot serve
	if (ALIGN_CODE > `ALIGN_MAX) begin : g_bad_align
		$error("ALIGN_CODE is a reserved alignment");
	end
	if (GRANULE_LOG2 < 12 || GRANULE_LOG2 > 16) begin : g_bad_granule
		$error("GRANULE_LOG2 out of range");
	end
	if (FIFO_DEPTH != 4) begin : g_bad_depth
		$error("FIFO_DEPTH must be 4");
	end
	if (REC_W < 1 || REC_W > 32) begin : g_bad_width
		$error("REC_W out of range");
	end

	// ----------------------------------------
	// Derived masks
	// ----------------------------------------
	// alignment low-bit mask
	localparam logic [63:0] ALIGN_MASK = (64'h0000_0000_0000_0001 << ALIGN_CODE) - 64'h1;
	localparam logic [63:0] LIMIT_MASK =
		~((64'h0000_0000_0000_0001 << GRANULE_LOG2) - 64'h1);
	localparam logic [63:0] UPPER_MASK = LIMIT_MASK | 64'h0000_0000_0000_0007;

	typedef struct packed {
		state_type state;
		logic [63:0] upper;
		logic [63:0] cursor;
		logic [5:0] ec;
		logic lost;
		logic ext_abort;
		logic service;
		logic overlap_seen_flag;
		logic [5:0] event_specific_syndrome;
		logic [63:0] rdata;
		logic ack;
		logic t2;
		logic t3;
		logic wr;
		logic [63:0] addr;
		logic [REC_W-1:0] len;
	} ctrl_state_type;

	ctrl_state_type st_r, st_nxt;
	logic f_valid, f_ready;
	logic [REC_W-1:0] f_len;
	logic [63:0] pad_len, end_addr, cur_len;
	logic enabled, prohib, own, acc_el2, acc_el3;
	logic [63:0] cap_val, synd_val;

	// ----------------------------------------
	// Record FIFO
	// ----------------------------------------
	prof_buf_fifo #(.WIDTH(REC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.srst(srst),
		.in_valid(rec_valid),
		.in_ready(rec_ready),
		.in_data(rec_len),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_len)
	);

	// ----------------------------------------
	// Access control and read values
	// ----------------------------------------
	always_comb begin
		prohib = 1'b0;
		unique case (cur_level)
			LVL_EL1_SECURE: prohib = top_level_ownership_field[1];
			LVL_EL1_NONSECURE: prohib = (hypervisor_ownership_field == `OWN_00) ||
				!top_level_ownership_field[1];
			LVL_EL2: prohib = !top_level_ownership_field[1];
			LVL_EL3: prohib = 1'b0;
		endcase
		acc_el2 = (cur_level == LVL_EL1_NONSECURE) &&
			(hypervisor_ownership_field == `OWN_00 || hypervisor_ownership_field == `OWN_10);
		acc_el3 = ((cur_level == LVL_EL1_SECURE) && top_level_ownership_field != `OWN_01) ||
			((cur_level == LVL_EL1_NONSECURE || cur_level == LVL_EL2) &&
			top_level_ownership_field != `OWN_11);
		cap_val = 64'h0;
		cap_val[`CAP_FLAG_BIT] = FLAG_UPDATE;
		cap_val[`CAP_PROHIB_BIT] = prohib;
		cap_val[3:0] = ALIGN_CODE;
		synd_val = 64'h0;
		synd_val[31:26] = st_r.ec;
		synd_val[`SYND_LOST_BIT] = st_r.lost;
		synd_val[`SYND_EXTAB_BIT] = st_r.ext_abort;
		synd_val[`SYND_SERVICE_BIT] = st_r.service;
		synd_val[`SYND_OVERLAP_SEEN_FLAG_BIT] = st_r.overlap_seen_flag;
		synd_val[5:0] = st_r.event_specific_syndrome;
	end

	assign enabled = st_r.upper[`UPPER_ENABLE_BIT];
	assign pad_len = ({{(64-REC_W){1'b0}}, f_len} + ALIGN_MASK) & ~ALIGN_MASK;
	assign end_addr = st_r.cursor + pad_len;
	assign f_ready = (st_r.state == ST_IDLE) && f_valid;
	assign own = (reg_sel == `REG_SEL_CAP) || (!acc_el2 && !acc_el3);
	// padded length of the write in flight
	assign cur_len = {{(64-REC_W){1'b0}}, st_r.len};

	// ----------------------------------------
	// Control process
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = reg_rd || reg_wr;
		st_nxt.t2 = (reg_rd || reg_wr) && !own && acc_el2;
		st_nxt.t3 = (reg_rd || reg_wr) && !own && !acc_el2;
		st_nxt.wr = 1'b0;
		if (collision_event) st_nxt.overlap_seen_flag = 1'b1;
		unique case (st_r.state)
			ST_IDLE: begin
				if (f_valid) begin
					if (!enabled) begin
						st_nxt.state = ST_FROZEN;
						st_nxt.lost = 1'b1;
						st_nxt.ec = `EC_OTHER;
						st_nxt.event_specific_syndrome = `BSC_NOT_FILLED;
					end else if (end_addr > {st_r.upper[63:12], 12'h000}) begin
						st_nxt.state = ST_FROZEN;
						st_nxt.lost = 1'b1;
						st_nxt.ec = `EC_OTHER;
						st_nxt.event_specific_syndrome = `BSC_FILLED;
					end else begin
						st_nxt.state = ST_WRITE;
						st_nxt.wr = 1'b1;
						st_nxt.addr = st_r.cursor;
						st_nxt.len = pad_len[REC_W-1:0];
					end
				end
			end
			ST_WRITE: begin
				if (mem_done) begin
					st_nxt.state = ST_IDLE;
					unique case (mem_fault)
						FAULT_NONE: begin
							st_nxt.cursor = st_r.cursor + cur_len;
							if (st_r.cursor + cur_len == {st_r.upper[63:12], 12'h000}) begin
								st_nxt.state = ST_FROZEN;
								st_nxt.lost = 1'b0;
								st_nxt.ec = `EC_OTHER;
								st_nxt.event_specific_syndrome = `BSC_FILLED;
							end
						end
						FAULT_STAGE1, FAULT_STAGE2: begin
							st_nxt.ec = (mem_fault == FAULT_STAGE1) ? `EC_STAGE1 : `EC_STAGE2;
							st_nxt.event_specific_syndrome = mem_fsc;
							st_nxt.lost = partial_write;
							st_nxt.state = ST_FROZEN;
						end
						FAULT_SYNC_EXT: begin
							st_nxt.ec = `EC_STAGE1;
							st_nxt.event_specific_syndrome = `FSC_SYNC_EXT;
							st_nxt.lost = partial_write;
							st_nxt.ext_abort = 1'b1;
							if (SYNC_ABORT_REPORT) st_nxt.cursor = st_r.cursor;
							st_nxt.state = ST_FROZEN;
						end
						default: begin
							st_nxt.ec = `EC_STAGE1;
							st_nxt.event_specific_syndrome = `FSC_ASYNC_EXT;
							st_nxt.lost = 1'b1;
							st_nxt.ext_abort = 1'b1;
							st_nxt.state = ST_FROZEN;
						end
					endcase
				end
			end
			ST_FROZEN: begin
				if (!st_r.service) st_nxt.state = ST_IDLE;
			end
			default: st_nxt.state = ST_IDLE;
		endcase
		st_nxt.service = (st_nxt.state == ST_FROZEN) && (st_r.state != ST_FROZEN) ?
			1'b1 : st_r.service;
		// Register reads
		if (reg_rd && own) begin
			unique case (reg_sel)
				`REG_SEL_CAP: st_nxt.rdata = cap_val;
				`REG_SEL_UPPER: st_nxt.rdata = st_r.upper;
				`REG_SEL_CURSOR: st_nxt.rdata = st_r.cursor;
				`REG_SEL_SYND: st_nxt.rdata = synd_val;
			endcase
		end else begin
			st_nxt.rdata = 64'h0;
		end
		// Register writes; hardware events in flight take priority
		if (reg_wr && own) begin
			unique case (reg_sel)
				`REG_SEL_CAP: st_nxt.upper = st_nxt.upper;
				`REG_SEL_UPPER: st_nxt.upper = reg_wdata & UPPER_MASK;
				`REG_SEL_CURSOR: if (st_r.state != ST_WRITE)
					st_nxt.cursor = SYNC_ABORT_REPORT ? reg_wdata : reg_wdata & ~ALIGN_MASK;
				`REG_SEL_SYND: if (!(st_nxt.state == ST_FROZEN && st_r.state != ST_FROZEN)) begin
					st_nxt.ec = reg_wdata[31:26];
					st_nxt.lost = reg_wdata[`SYND_LOST_BIT];
					st_nxt.ext_abort = reg_wdata[`SYND_EXTAB_BIT];
					st_nxt.service = reg_wdata[`SYND_SERVICE_BIT];
					st_nxt.overlap_seen_flag = reg_wdata[`SYND_OVERLAP_SEEN_FLAG_BIT] | collision_event;
					st_nxt.event_specific_syndrome = reg_wdata[5:0];
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_r <= '0;
			st_r.upper <= `UPPER_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reg_rdata = st_r.rdata;
	assign reg_ack = st_r.ack;
	assign trap_el2 = st_r.t2;
	assign trap_el3 = st_r.t3;
	assign mem_wr = st_r.wr;
	assign mem_addr = st_r.addr;
	assign mem_len = st_r.len;
	assign buffer_management_interrupt = st_r.service;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_FROZEN_CURSOR: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_FROZEN && !(reg_wr && reg_sel == `REG_SEL_CURSOR)
		|=> st_r.cursor == $past(st_r.cursor)) else $error("cursor moved while frozen");
	AST_SERVICE_IRQ: assert property (@(posedge clock) disable iff (srst)
		(st_r.state != ST_FROZEN) ##1 (st_r.state == ST_FROZEN) |-> buffer_management_interrupt)
		else $error("interrupt not raised on event");
	AST_NO_WRITE_DISABLED: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_IDLE && f_valid && !enabled |=> !mem_wr)
		else $error("write while disabled");
	AST_DISABLED_EVENT: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_IDLE && f_valid && !enabled |=> st_r.lost && st_r.event_specific_syndrome == 6'h00)
		else $error("disabled event syndrome wrong");
	AST_ASYNC_LOST: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_WRITE && mem_done && mem_fault == FAULT_ASYNC_EXT
		|=> st_r.lost && st_r.ext_abort) else $error("async abort not flagged");
	AST_STAGE2_EC: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_WRITE && mem_done && mem_fault == FAULT_STAGE2
		|=> st_r.ec == 6'h25) else $error("stage 2 class wrong");
	AST_OVERLAP_SEEN_FLAG_STICKY: assert property (@(posedge clock) disable iff (srst)
		collision_event |=> st_r.overlap_seen_flag) else $error("collision lost");
	AST_ADVANCE: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_WRITE && mem_done && mem_fault == FAULT_NONE
		|=> st_r.cursor == $past(st_r.cursor) + 64'($past(mem_len))) else $error("bad advance");
	AST_TRAP_EL2: assert property (@(posedge clock) disable iff (srst)
		reg_rd && cur_level == LVL_EL1_NONSECURE && hypervisor_ownership_field == 2'b00 &&
		reg_sel != `REG_SEL_CAP
		|=> trap_el2 && reg_rdata == 64'h0) else $error("missing trap to EL2");
	AST_LIMIT_ALIGN: assert property (@(posedge clock) disable iff (srst)
		st_r.upper[11:3] == 9'h000) else $error("limit reserved bits set");
	AST_PAD_LEN: assert property (@(posedge clock) disable iff (srst)
		mem_wr |-> (64'(mem_len) & ALIGN_MASK) == 64'h0)
		else $error("record length not padded");
	AST_FILL_DROP: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_IDLE && f_valid && enabled && end_addr > {st_r.upper[63:12], 12'h000}
		|=> st_r.state == ST_FROZEN && st_r.event_specific_syndrome == 6'h01 && !mem_wr)
		else $error("fill did not stop collection");
	AST_CAP_NO_TRAP: assert property (@(posedge clock) disable iff (srst)
		reg_rd && reg_sel == `REG_SEL_CAP |=> !trap_el2 && !trap_el3)
		else $error("capability read trapped");
	AST_TRAP_EL3: assert property (@(posedge clock) disable iff (srst)
		reg_rd && cur_level == LVL_EL1_SECURE && top_level_ownership_field != 2'b01 &&
		reg_sel != `REG_SEL_CAP |=> trap_el3 && reg_rdata == 64'h0)
		else $error("missing trap to EL3");
	AST_SYNC_EA: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_WRITE && mem_done && mem_fault == FAULT_SYNC_EXT
		|=> st_r.ext_abort && st_r.event_specific_syndrome == 6'h10) else $error("sync abort not flagged");
	AST_FROZEN_NO_WRITE: assert property (@(posedge clock) disable iff (srst)
		st_r.state == ST_FROZEN |=> !mem_wr) else $error("write started while frozen");
endmodule : prof_buf_ctrl

`default_nettype wire

// *** prof_buf_fifo.sv ***
// Small record FIFO between the record source and the memory writer.
// Assumes a single clock and a synchronous active-high reset.
`default_nettype none

module prof_buf_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// Refuse depths the pointer scheme cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two >= 2");
	end

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
		logic space;
	} fifo_state_type;

	fifo_state_type st_r, st_nxt;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic full, empty;

	// Occupancy flags from pointers
	assign empty = st_r.wr_ptr == st_r.rd_ptr;
	assign full = !st_r.space;
	assign in_ready = st_r.space; // Straight from a flip-flop
	assign out_valid = !empty;
	assign out_data = mem_r[st_r.rd_ptr[AW-1:0]];

	// Pointer update
	always_comb begin
		st_nxt = st_r;
		if (in_valid && !full) st_nxt.wr_ptr = st_r.wr_ptr + 1'b1;
		if (out_ready && !empty) st_nxt.rd_ptr = st_r.rd_ptr + 1'b1;
		// Free-space flag kept registered so in_ready needs no logic
		st_nxt.space = !((st_nxt.wr_ptr[AW] != st_nxt.rd_ptr[AW]) &&
			(st_nxt.wr_ptr[AW-1:0] == st_nxt.rd_ptr[AW-1:0]));
	end

	// Storage and pointer registers
	always_ff @(posedge clock) begin
		if (srst) begin
			st_r <= '{wr_ptr: '0, rd_ptr: '0, space: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
		if (in_valid && !full) mem_r[st_r.wr_ptr[AW-1:0]] <= in_data;
	end
endmodule : prof_buf_fifo

`default_nettype wire

// *** prof_buf_mem_model.sv ***
// Memory-side model that answers record writes after a set latency.
// Assumes the bench sets latency and the fault to report per write.
`default_nettype none

module prof_buf_mem_model
	import prof_buf_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Write port
	input wire logic mem_wr,
	output logic mem_done,
	output prof_buf_pkg::fault_type mem_fault,
	output logic [5:0] mem_fsc,
	output logic partial_write,
	// Behaviour chosen by the bench
	input wire logic [7:0] latency,
	input wire prof_buf_pkg::fault_type fault_sel,
	input wire logic [5:0] fsc_sel,
	input wire logic partial_sel
);
	timeunit 1ns;
	timeprecision 1ns;

	logic busy = 1'b0;
	logic [7:0] cnt = 8'h00;

	// One answer per write, latency plus one cycles after mem_wr is sampled
	always @(posedge clock) begin
		mem_done <= 1'b0;
		if (srst) begin
			busy <= 1'b0;
		end else if (mem_wr) begin
			busy <= 1'b1;
			cnt <= latency;
		end else if (busy) begin
			if (cnt == 8'h00) begin
				busy <= 1'b0;
				mem_done <= 1'b1;
			end else begin
				cnt <= cnt - 8'h01;
			end
		end
	end

	// Fault lines carry junk outside the answer cycle
	assign mem_fault = mem_done ? fault_sel : (fault_sel == FAULT_NONE ? FAULT_ASYNC_EXT : FAULT_NONE);
	assign mem_fsc = mem_done ? fsc_sel : ~fsc_sel;
	assign partial_write = mem_done ? partial_sel : ~partial_sel;
endmodule : prof_buf_mem_model

`default_nettype wire

// *** prof_buf_pkg.sv ***
// Types for the profiling buffer control block.
// Assumes prof_buf_consts.svh is on the include path.
`default_nettype none
`include "prof_buf_consts.svh"

package prof_buf_pkg;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WRITE = 2'b01,
		ST_FROZEN = 2'b11
	} state_type;

	typedef enum logic [1:0] {
		LVL_EL1_SECURE = 2'b00,
		LVL_EL1_NONSECURE = 2'b01,
		LVL_EL2 = 2'b10,
		LVL_EL3 = 2'b11
	} level_type;

	typedef enum logic [2:0] {
		FAULT_NONE = 3'h0,
		FAULT_STAGE1 = 3'h1,
		FAULT_STAGE2 = 3'h2,
		FAULT_SYNC_EXT = 3'h3,
		FAULT_ASYNC_EXT = 3'h4
	} fault_type;
endpackage : prof_buf_pkg

`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the profiling buffer control block.
// Assumes the memory model above and the design's package and header.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import prof_buf_pkg::*;

	localparam logic [3:0] ALIGN = 4'h3;
	localparam logic FLAG = 1'b1;

	logic clock = 1'b0, srst = 1'b1, reg_rd = 1'b0, reg_wr = 1'b0, rec_valid = 1'b0;
	logic collision_event = 1'b0, partial_sel = 1'b0;
	logic [1:0] reg_sel = 2'h0, top_f = 2'h3, hyp_f = 2'h1;
	logic [63:0] reg_wdata = 64'h0, reg_rdata, mem_addr, rd, last_addr;
	level_type cur_level = LVL_EL3;
	logic reg_ack, trap_el2, trap_el3, rec_ready, mem_wr, mem_done, partial_write, irq, t2, t3;
	logic [15:0] rec_len = 16'h0000, mem_len, last_len;
	fault_type mem_fault, fault_sel = FAULT_NONE;
	logic [5:0] mem_fsc, fsc_sel = 6'h00;
	logic [7:0] latency = 8'h02;
	int failures = 0, comparisons = 0, wr_count = 0, done_count = 0;

	prof_buf_ctrl #(.ALIGN_CODE(ALIGN), .FLAG_UPDATE(FLAG)) u_dut (.clock(clock), .srst(srst),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
		.cur_level(cur_level), .top_level_ownership_field(top_f),
		.hypervisor_ownership_field(hyp_f), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.trap_el2(trap_el2), .trap_el3(trap_el3), .rec_valid(rec_valid), .rec_ready(rec_ready),
		.rec_len(rec_len), .collision_event(collision_event), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_len(mem_len), .mem_done(mem_done), .mem_fault(mem_fault),
		.mem_fsc(mem_fsc), .partial_write(partial_write), .buffer_management_interrupt(irq));

	prof_buf_mem_model u_mem (.clock(clock), .srst(srst), .mem_wr(mem_wr),
		.mem_done(mem_done), .mem_fault(mem_fault), .mem_fsc(mem_fsc),
		.partial_write(partial_write), .latency(latency), .fault_sel(fault_sel),
		.fsc_sel(fsc_sel), .partial_sel(partial_sel));

	// Clock
	initial begin
		forever #50 clock = ~clock;
	end

	// Write port monitor
	always @(posedge clock) begin
		if (mem_wr) begin
			wr_count <= wr_count + 1;
			last_addr <= mem_addr;
			last_len <= mem_len;
		end
		if (mem_done) done_count <= done_count + 1;
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize

	task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic bail(input string name);
		failures++;
		$display("[FAIL] %s expected event seen timeout", name);
		summarize();
	endtask : bail

	task automatic do_reset();
		srst <= 1'b1;
		repeat (4) @(posedge clock);
		srst <= 1'b0;
	endtask : do_reset

	task automatic acc(input logic wr, input logic [1:0] sel, input logic [63:0] d);
		@(posedge clock);
		reg_rd <= !wr;
		reg_wr <= wr;
		reg_sel <= sel;
		reg_wdata <= d;
		@(posedge clock);
		reg_rd <= 1'b0;
		reg_wr <= 1'b0;
		// Answer stands for this cycle; sample it mid-cycle
		@(negedge clock);
		if (reg_ack !== 1'b1) bail("reg_ack");
		rd = reg_rdata;
		t2 = trap_el2;
		t3 = trap_el3;
		@(posedge clock);
	endtask : acc

	task automatic push(input logic [15:0] len, output logic ok);
		@(posedge clock);
		rec_valid <= 1'b1;
		rec_len <= len;
		ok = 1'b0;
		for (int i = 0; i < 3 && !ok; i++) begin
			@(negedge clock);
			ok = (rec_ready === 1'b1);
			@(posedge clock);
		end
		rec_valid <= 1'b0;
	endtask : push

	task automatic wait_irq(input logic v);
		for (int i = 0; i < 100; i++) begin
			@(negedge clock);
			if (irq === v) begin
				@(posedge clock);
				return;
			end
		end
		bail("irq");
	endtask : wait_irq

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset_cap();
		do_reset();
		acc(1'b0, 2'h1, 64'h0); check("upper reset", 64'h0, rd);
		acc(1'b0, 2'h0, 64'h0); check("capability", {58'h0, FLAG, 1'b0, ALIGN}, rd);
		$display("test reset_cap done");
	endtask : t_reset_cap

	task automatic t_owner();
		logic p, e2, e3;
		do_reset();
		for (int l = 0; l < 4; l++) for (int t = 0; t < 4; t++) for (int h = 0; h < 4; h++) begin
			cur_level <= level_type'(l);
			top_f <= t[1:0];
			hyp_f <= h[1:0];
			p = (l == 0 && t[1]) || (l == 1 && h == 0) || ((l == 1 || l == 2) && !t[1]);
			e2 = l == 1 && (h == 0 || h == 2);
			e3 = !e2 && ((l == 0 && t != 1) || ((l == 1 || l == 2) && t != 3));
			acc(1'b0, 2'h0, 64'h0); check("prohibited", 64'(p), 64'(rd[4]));
			acc(1'b0, 2'h3, 64'h0); check("traps", 64'({e2, e3}), 64'({t2, t3}));
		end
		cur_level <= LVL_EL1_NONSECURE;
		hyp_f <= 2'h0;
		acc(1'b1, 2'h2, 64'h8000); check("write trap", 64'h1, 64'(t2));
		cur_level <= LVL_EL3;
		acc(1'b0, 2'h2, 64'h0); check("trapped write", 64'h0, rd);
		$display("test owner done");
	endtask : t_owner

	task automatic t_fill_mode();
		do_reset();
		for (int f = 0; f < 4; f++) begin
			acc(1'b1, 2'h1, 64'h0001_0000_0000_0000 | 64'(f * 2));
			acc(1'b0, 2'h1, 64'h0);
			check("upper readback", 64'h0001_0000_0000_0000 | 64'(f * 2), rd);
		end
		$display("test fill_mode done");
	endtask : t_fill_mode

	task automatic t_stream();
		logic ok;
		int n, d0;
		do_reset();
		latency <= 8'h28;
		acc(1'b1, 2'h2, 64'h2000);
		acc(1'b1, 2'h1, 64'h3001);
		d0 = done_count;
		n = 0;
		ok = 1'b1;
		while (ok && n < 8) begin
			push(16'h0005, ok);
			if (ok) n++;
		end
		check("fifo refused", 64'h0, 64'(ok));
		check("accepted", 64'h5, 64'(n));
		check("first addr", 64'h2000, last_addr);
		check("padded len", 64'h8, 64'(last_len));
		latency <= 8'h01;
		for (int i = 0; i < 400 && done_count < d0 + n; i++) @(posedge clock);
		if (done_count < d0 + n) bail("drain");
		repeat (2) @(posedge clock);
		acc(1'b0, 2'h2, 64'h0); check("cursor", 64'h2000 + 64'(8 * n), rd);
		check("last addr", 64'h2000 + 64'(8 * (n - 1)), last_addr);
		$display("test stream done");
	endtask : t_stream

	task automatic t_full();
		logic ok;
		int w;
		do_reset();
		latency <= 8'h03;
		acc(1'b1, 2'h2, 64'h4ff8);
		acc(1'b1, 2'h1, 64'h5001);
		push(16'h0008, ok);
		wait_irq(1'b1);
		acc(1'b0, 2'h3, 64'h0); check("fill syndrome", 64'h0002_0001, rd);
		w = wr_count;
		push(16'h0008, ok);
		repeat (10) @(posedge clock);
		check("no write frozen", 64'(w), 64'(wr_count));
		acc(1'b0, 2'h2, 64'h0); check("cursor frozen", 64'h5000, rd);
		acc(1'b1, 2'h3, 64'h0);
		wait_irq(1'b0);
		$display("test full done");
	endtask : t_full

	task automatic t_faults();
		fault_type ft[4] = '{FAULT_STAGE1, FAULT_STAGE2, FAULT_SYNC_EXT, FAULT_ASYNC_EXT};
		logic [5:0] fs[4] = '{6'h05, 6'h0e, 6'h10, 6'h11};
		logic [63:0] ex[4] = '{64'h9002_0005, 64'h940a_000e, 64'h9006_0010, 64'h900e_0011};
		logic ok;
		for (int i = 0; i < 4; i++) begin
			do_reset();
			fault_sel <= ft[i];
			fsc_sel <= fs[i];
			partial_sel <= (i == 1);
			acc(1'b1, 2'h2, 64'h6000);
			acc(1'b1, 2'h1, 64'h7001);
			push(16'h0008, ok);
			wait_irq(1'b1);
			acc(1'b0, 2'h3, 64'h0);
			check("fault syndrome", ex[i], rd & ~(i == 2 ? 64'h8_0000 : 64'h0));
			acc(1'b0, 2'h2, 64'h0); check("fault cursor", 64'h6000, rd & ~64'h7);
		end
		fault_sel <= FAULT_NONE;
		partial_sel <= 1'b0;
		$display("test faults done");
	endtask : t_faults

	task automatic t_disabled();
		logic ok;
		int w;
		do_reset();
		acc(1'b1, 2'h2, 64'h8000);
		acc(1'b1, 2'h1, 64'h9000);
		w = wr_count;
		push(16'h0008, ok);
		wait_irq(1'b1);
		check("no write disabled", 64'(w), 64'(wr_count));
		acc(1'b0, 2'h3, 64'h0); check("disabled syndrome", 64'h000a_0000, rd);
		$display("test disabled done");
	endtask : t_disabled

	task automatic t_collision();
		do_reset();
		@(posedge clock);
		collision_event <= 1'b1;
		@(posedge clock);
		collision_event <= 1'b0;
		acc(1'b0, 2'h3, 64'h0); check("collision set", 64'h0001_0000, rd);
		acc(1'b1, 2'h3, 64'h0);
		acc(1'b0, 2'h3, 64'h0); check("collision clear", 64'h0, rd);
		$display("test collision done");
	endtask : t_collision

	// Main sequence
	initial begin
		t_reset_cap();
		t_owner();
		t_fill_mode();
		t_stream();
		t_full();
		t_faults();
		t_disabled();
		t_collision();
		summarize();
	end
endmodule : tb_top

`default_nettype wire
